// ==== src/adc_input_mix_routing_regs.sv ====
`timescale 1ns/1ps
module adc_input_mix_routing_regs (
   input  wire logic                               core_clk_i,
   input  wire logic                               reset_i,
   input  wire logic [adc_mix_routing_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic                               reg_wr_i,
   input  wire logic [adc_mix_routing_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                               reg_rd_i,
   output logic      [adc_mix_routing_pkg::DATA_W-1:0] reg_rdata_o,
   output logic                                    reg_hit_o,
   output logic      [adc_mix_routing_pkg::ROUTE_COUNT-1:0] route_connect_o,
   output adc_mix_routing_pkg::atten_t [adc_mix_routing_pkg::ROUTE_COUNT-1:0]
                                                   route_atten_o,
   output logic                                    line_one_left_diff_o,
   output logic                                    left_adc_power_up_o,
   input  wire adc_mix_routing_pkg::gain_t         left_pga_target_i,
   input  wire logic                               sample_tick_i,
   output adc_mix_routing_pkg::gain_t              left_pga_gain_o,
   output logic                                    left_pga_stepping_o,
   output logic                                    reserved_code_write_o
);
   import adc_mix_routing_pkg::*;

   // ==========================================================
   // storage
   logic [DATA_W-1:0] mic_three_to_left_adc_mix;
   logic [DATA_W-1:0] mic_three_to_right_adc_mix;
   logic [DATA_W-1:0] line_one_left_to_left_adc_mix;

   // ==========================================================
   // address decode
   wire logic sel_mic_left;
   wire logic sel_mic_right;
   wire logic sel_line_left;
   wire logic sel_any;
   wire logic wr_mic_left;
   wire logic wr_mic_right;
   wire logic wr_line_left;

   assign sel_mic_left  = (reg_addr_i == MIC_THREE_TO_LEFT_ADC_MIX_ADDR);
   assign sel_mic_right = (reg_addr_i == MIC_THREE_TO_RIGHT_ADC_MIX_ADDR);
   assign sel_line_left = (reg_addr_i == LINE_ONE_LEFT_TO_LEFT_ADC_MIX_ADDR);
   assign sel_any       = sel_mic_left || sel_mic_right || sel_line_left;
   assign wr_mic_left   = reg_wr_i && sel_mic_left;
   assign wr_mic_right  = reg_wr_i && sel_mic_right;
   assign wr_line_left  = reg_wr_i && sel_line_left;

   // ==========================================================
   // register writes
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         mic_three_to_left_adc_mix     <= MIC_MIX_RESET;
         mic_three_to_right_adc_mix    <= MIC_MIX_RESET;
         line_one_left_to_left_adc_mix <= LINE_MIX_RESET;
      end else begin
         if (wr_mic_left) begin
            mic_three_to_left_adc_mix <= reg_wdata_i;
         end
         if (wr_mic_right) begin
            mic_three_to_right_adc_mix <= reg_wdata_i;
         end
         if (wr_line_left) begin
            line_one_left_to_left_adc_mix <= reg_wdata_i;
         end
      end
   end

   // ==========================================================
   // read back
   wire logic [DATA_W-1:0] read_mux;

   assign read_mux =
      sel_mic_left  ? mic_three_to_left_adc_mix :
      sel_mic_right ? mic_three_to_right_adc_mix :
      sel_line_left ? line_one_left_to_left_adc_mix : '0;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= '0;
         reg_hit_o   <= 1'b0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= read_mux;
         reg_hit_o   <= sel_any;
      end
   end

   // ==========================================================
   // field extraction
   level_code_t level_field [ROUTE_COUNT];

   assign level_field[ROUTE_MIC_LEFT_TO_LEFT] =
      mic_three_to_left_adc_mix[HI_LEVEL_LSB +: LEVEL_W];
   assign level_field[ROUTE_MIC_RIGHT_TO_LEFT] =
      mic_three_to_left_adc_mix[LO_LEVEL_LSB +: LEVEL_W];
   assign level_field[ROUTE_MIC_LEFT_TO_RIGHT] =
      mic_three_to_right_adc_mix[HI_LEVEL_LSB +: LEVEL_W];
   assign level_field[ROUTE_MIC_RIGHT_TO_RIGHT] =
      mic_three_to_right_adc_mix[LO_LEVEL_LSB +: LEVEL_W];
   assign level_field[ROUTE_LINE_LEFT_TO_LEFT] =
      line_one_left_to_left_adc_mix[LINE_LEVEL_LSB +: LEVEL_W];

   // ==========================================================
   // level decoders, one per routed input
   genvar r;
   generate
      for (r = 0; r < ROUTE_COUNT; r++) begin : g_route
         mix_level_decoder u_dec (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .code_i     (level_field[r]),
            .connect_o  (route_connect_o[r]),
            .atten_o    (route_atten_o[r])
         );
      end
   endgenerate

   // ==========================================================
   // reserved level code watch
   // flags a write that puts a reserved code in any level field; the
   // decoders still treat such a code as disconnected
   function automatic logic is_reserved(input level_code_t c);
      is_reserved = (c > LEVEL_MAX_ATTEN) && (c != LEVEL_DISCONNECT);
   endfunction

   wire logic bad_hi;
   wire logic bad_lo;
   wire logic bad_line;
   wire logic bad_write;

   assign bad_hi    = is_reserved(reg_wdata_i[HI_LEVEL_LSB +: LEVEL_W]);
   assign bad_lo    = is_reserved(reg_wdata_i[LO_LEVEL_LSB +: LEVEL_W]);
   assign bad_line  = is_reserved(reg_wdata_i[LINE_LEVEL_LSB +: LEVEL_W]);
   assign bad_write = ((wr_mic_left || wr_mic_right) && (bad_hi || bad_lo)) ||
                      (wr_line_left && bad_line);

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         reserved_code_write_o <= 1'b0;
      end else begin
         reserved_code_write_o <= bad_write;
      end
   end

   // ==========================================================
   // mode and power controls
   // the right-side copy of the line mode lives elsewhere; software keeps
   // both copies equal, nothing here cross-checks them
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         line_one_left_diff_o <= 1'b0;
         left_adc_power_up_o  <= 1'b0;
      end else begin
         line_one_left_diff_o <=
            line_one_left_to_left_adc_mix[LINE_DIFF_BIT];
         left_adc_power_up_o  <=
            line_one_left_to_left_adc_mix[ADC_POWER_BIT];
      end
   end

   // ==========================================================
   // left gain soft stepping
   gain_step_if step_bus ();

   assign step_bus.target = left_pga_target_i;
   assign step_bus.rate   = step_rate_t'(
      line_one_left_to_left_adc_mix[STEP_RATE_LSB +: STEP_RATE_W]
   );
   assign step_bus.tick   = sample_tick_i;

   pga_gain_stepper u_stepper (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .step       (step_bus.stepper)
   );

   assign left_pga_gain_o     = step_bus.gain;
   assign left_pga_stepping_o = step_bus.busy;

endmodule

// ==== src/adc_mix_routing_pkg.sv ====
package adc_mix_routing_pkg;

   // ==========================================================
   // register map
   localparam int  ADDR_W              = 8;
   localparam int  DATA_W              = 8;
   localparam logic [ADDR_W-1:0] MIC_THREE_TO_LEFT_ADC_MIX_ADDR     = 8'h11;
   localparam logic [ADDR_W-1:0] MIC_THREE_TO_RIGHT_ADC_MIX_ADDR    = 8'h12;
   localparam logic [ADDR_W-1:0] LINE_ONE_LEFT_TO_LEFT_ADC_MIX_ADDR = 8'h13;

   // ==========================================================
   // field layout
   localparam int  LEVEL_W             = 4;
   localparam int  HI_LEVEL_LSB        = 4;
   localparam int  LO_LEVEL_LSB        = 0;
   localparam int  LINE_LEVEL_LSB      = 3;
   localparam int  LINE_DIFF_BIT       = 7;
   localparam int  ADC_POWER_BIT       = 2;
   localparam int  STEP_RATE_LSB       = 0;
   localparam int  STEP_RATE_W         = 2;

   // ==========================================================
   // reset values
   localparam logic [DATA_W-1:0] MIC_MIX_RESET  = 8'hff;
   localparam logic [DATA_W-1:0] LINE_MIX_RESET = 8'h78;

   // ==========================================================
   // level codes
   localparam logic [LEVEL_W-1:0] LEVEL_MAX_ATTEN  = 4'h8;
   localparam logic [LEVEL_W-1:0] LEVEL_DISCONNECT = 4'hf;
   // attenuation reported in half-dB units: one code step is three units
   localparam int  ATTEN_W             = 5;
   localparam logic [ATTEN_W-1:0] ATTEN_PER_CODE = 5'h03;

   // ==========================================================
   // routed inputs, one per level field
   localparam int  ROUTE_COUNT         = 5;
   localparam int  ROUTE_MIC_LEFT_TO_LEFT   = 0;
   localparam int  ROUTE_MIC_RIGHT_TO_LEFT  = 1;
   localparam int  ROUTE_MIC_LEFT_TO_RIGHT  = 2;
   localparam int  ROUTE_MIC_RIGHT_TO_RIGHT = 3;
   localparam int  ROUTE_LINE_LEFT_TO_LEFT  = 4;

   // ==========================================================
   // gain stepping
   localparam int  GAIN_W              = 7;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 7'h00;
   localparam logic [GAIN_W-1:0] GAIN_STEP  = 7'h01;

   typedef enum logic [STEP_RATE_W-1:0] {
      STEP_EVERY_SAMPLE = 2'b00,
      STEP_EVERY_TWO    = 2'b01,
      STEP_OFF_A        = 2'b10,
      STEP_OFF_B        = 2'b11
   } step_rate_t;

   typedef logic [LEVEL_W-1:0] level_code_t;
   typedef logic [ATTEN_W-1:0] atten_t;
   typedef logic [GAIN_W-1:0]  gain_t;

endpackage

// ==== src/gain_step_if.sv ====
`timescale 1ns/1ps
interface gain_step_if;
   import adc_mix_routing_pkg::*;

   gain_t       target;
   step_rate_t  rate;
   logic        tick;
   gain_t       gain;
   logic        busy;

   modport ctrl (
      output target,
      output rate,
      output tick,
      input  gain,
      input  busy
   );

   modport stepper (
      input  target,
      input  rate,
      input  tick,
      output gain,
      output busy
   );
endinterface

// ==== src/mix_level_decoder.sv ====
`timescale 1ns/1ps
module mix_level_decoder (
   input  wire logic                        core_clk_i,
   input  wire logic                        reset_i,
   input  wire adc_mix_routing_pkg::level_code_t code_i,
   output logic                             connect_o,
   output adc_mix_routing_pkg::atten_t      atten_o
);
   import adc_mix_routing_pkg::*;

   // ==========================================================
   // decode
   wire logic   valid_code;
   wire atten_t next_atten;

   // reserved codes are treated as disconnected so a stray write is silent
   assign valid_code = (code_i <= LEVEL_MAX_ATTEN);
   assign next_atten = valid_code ?
      atten_t'(code_i) * ATTEN_PER_CODE : '0;

   // ==========================================================
   // registered outputs
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         connect_o <= 1'b0;
         atten_o   <= '0;
      end else begin
         connect_o <= valid_code;
         atten_o   <= next_atten;
      end
   end
endmodule

// ==== src/pga_gain_stepper.sv ====
`timescale 1ns/1ps
module pga_gain_stepper (
   input  wire logic    core_clk_i,
   input  wire logic    reset_i,
   gain_step_if.stepper step
);
   import adc_mix_routing_pkg::*;

   // ==========================================================
   // interval selection
   logic  half_phase;
   wire logic  stepping_on;
   wire logic  step_now;
   wire logic  go_up;
   wire logic  at_target;
   wire gain_t next_gain;

   assign stepping_on = (step.rate == STEP_EVERY_SAMPLE) ||
                        (step.rate == STEP_EVERY_TWO);
   assign step_now    = step.tick &&
      ((step.rate == STEP_EVERY_SAMPLE) || half_phase);
   assign at_target   = (step.gain == step.target);
   assign go_up       = (step.target > step.gain);
   assign next_gain   = !stepping_on ? step.target :
                        (at_target || !step_now) ? step.gain :
                        go_up ? step.gain + GAIN_STEP :
                                step.gain - GAIN_STEP;
   assign step.busy   = stepping_on && !at_target;

   // ==========================================================
   // state
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         step.gain  <= GAIN_RESET;
         half_phase <= 1'b0;
      end else begin
         step.gain <= next_gain;
         // the phase toggles per sample so every-two waits a full pair
         if (step.tick) begin
            half_phase <= !half_phase;
         end
      end
   end
endmodule

// ==== verification/adc_input_mix_routing_regs_asserts.sv ====
`timescale 1ns/1ps
module adc_input_mix_routing_regs_asserts (
   input wire logic                              core_clk_i,
   input wire logic                              reset_i,
   input wire logic [7:0]                        reg_addr_i,
   input wire logic                              reg_wr_i,
   input wire logic [7:0]                        reg_wdata_i,
   input wire logic                              reg_rd_i,
   input wire logic [7:0]                        reg_rdata_o,
   input wire logic                              reg_hit_o,
   input wire logic [4:0]                        route_connect_o,
   input wire adc_mix_routing_pkg::atten_t [4:0] route_atten_o,
   input wire logic                              line_one_left_diff_o,
   input wire logic                              left_adc_power_up_o,
   input wire adc_mix_routing_pkg::gain_t        left_pga_target_i,
   input wire logic                              sample_tick_i,
   input wire adc_mix_routing_pkg::gain_t        left_pga_gain_o,
   input wire logic                              left_pga_stepping_o,
   input wire logic                              reserved_code_write_o
);
   import adc_mix_routing_pkg::*;

   // ==========
   // rate shadow: the register file itself is not visible here
   logic [1:0] rate_q;

   always_ff @(posedge core_clk_i) begin
      if (reset_i)
         rate_q <= 2'h0;
      else if (reg_wr_i && reg_addr_i == 8'h13)
         rate_q <= reg_wdata_i[1:0];
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   // ==========
   // properties
   sequence wr_to(logic [7:0] a);
      reg_wr_i && reg_addr_i == a;
   endsequence

   property mix_p(logic [7:0] a, int lsb, int r);
      wr_to(a) ##0 (reg_wdata_i[lsb+:4] <= 4'h8) |-> ##2
         (route_connect_o[r] &&
          route_atten_o[r] == 5'(3 * $past(reg_wdata_i[lsb+:4], 2)));
   endproperty

   property off_p(logic [7:0] a, int lsb, int r);
      wr_to(a) ##0 (reg_wdata_i[lsb+:4] > 4'h8) |-> ##2
         (!route_connect_o[r] && route_atten_o[r] == 5'h00);
   endproperty

   property bit_p(o, int b);
      wr_to(8'h13) |-> ##2 (o == $past(reg_wdata_i[b], 2));
   endproperty

   // a change of rate needs one settled cycle before it is trusted
   property step_p;
      (rate_q == 2'h0 && $stable(rate_q) && sample_tick_i &&
       left_pga_stepping_o) |=>
         (left_pga_gain_o - $past(left_pga_gain_o) == 7'h01 ||
          $past(left_pga_gain_o) - left_pga_gain_o == 7'h01);
   endproperty

   property imm_p;
      (rate_q[1] && $stable(rate_q)) |=>
         left_pga_gain_o == $past(left_pga_target_i);
   endproperty

   property unm_p;
      (reg_rd_i && !(reg_addr_i inside {[8'h11:8'h13]})) |=>
         (!reg_hit_o && reg_rdata_o == 8'h00);
   endproperty

   chk_route_zero_level: assert property (mix_p(8'h11, 4, 0))
      else $error("route 0 level wrong");
   chk_route_one_level: assert property (mix_p(8'h11, 0, 1))
      else $error("route 1 level wrong");
   chk_route_two_level: assert property (mix_p(8'h12, 4, 2))
      else $error("route 2 level wrong");
   chk_route_three_level: assert property (mix_p(8'h12, 0, 3))
      else $error("route 3 level wrong");
   chk_line_level: assert property (mix_p(8'h13, 3, 4))
      else $error("route 4 level wrong");
   chk_line_disconnect: assert property (off_p(8'h13, 3, 4))
      else $error("route 4 not disconnected");
   chk_diff_mode: assert property (bit_p(line_one_left_diff_o, 7))
      else $error("line mode bit wrong");
   chk_power_bit: assert property (bit_p(left_adc_power_up_o, 2))
      else $error("power bit wrong");
   chk_step_once: assert property (step_p)
      else $error("gain step size wrong");
   chk_step_off: assert property (imm_p)
      else $error("gain not applied at once");
   chk_unmapped_read: assert property (unm_p)
      else $error("unmapped read not empty");
endmodule

bind adc_input_mix_routing_regs adc_input_mix_routing_regs_asserts chk (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
   .route_connect_o(route_connect_o), .route_atten_o(route_atten_o),
   .line_one_left_diff_o(line_one_left_diff_o),
   .left_adc_power_up_o(left_adc_power_up_o),
   .left_pga_target_i(left_pga_target_i), .sample_tick_i(sample_tick_i),
   .left_pga_gain_o(left_pga_gain_o),
   .left_pga_stepping_o(left_pga_stepping_o),
   .reserved_code_write_o(reserved_code_write_o)
);

// ==== verification/adc_input_mix_routing_regs_bench.sv ====
`timescale 1ns/1ps
module adc_input_mix_routing_regs_bench;
   import adc_mix_routing_pkg::*;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
      logic       hit;
   } row_t;

   // ==========
   // stimulus and observed signals
   logic                   clk;
   logic                   rst = 1'b1;
   logic [7:0]             addr = 8'h00;
   logic                   wr = 1'b0;
   logic [7:0]             wd = 8'h00;
   logic                   rd = 1'b0;
   gain_t                  tgt = 7'h00;
   logic                   tick = 1'b0;
   logic [7:0]             rdata;
   logic                   hit;
   logic [ROUTE_COUNT-1:0] conn;
   atten_t [ROUTE_COUNT-1:0] atten;
   logic                   diff;
   logic                   pwr;
   gain_t                  gain;
   logic                   stp;
   logic                   rsv;
   logic [7:0]             sh [3] = '{8'hff, 8'hff, 8'h78};
   int                     num_errors = 0;
   int                     comparisons = 0;
   // reserved codes and unmapped places sit among the plain rows
   row_t rows [8] = '{'{8'h11, 8'h08, 8'h08, 1'b1},
      '{8'h12, 8'hf0, 8'hf0, 1'b1}, '{8'h13, 8'hfc, 8'hfc, 1'b1},
      '{8'h13, 8'h84, 8'h84, 1'b1}, '{8'h11, 8'h9e, 8'h9e, 1'b1},
      '{8'h12, 8'h7f, 8'h7f, 1'b1}, '{8'h20, 8'h55, 8'h00, 1'b0},
      '{8'h10, 8'h00, 8'h00, 1'b0}};

   adc_input_mix_routing_regs uut (
      .core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_hit_o(hit), .route_connect_o(conn), .route_atten_o(atten),
      .line_one_left_diff_o(diff), .left_adc_power_up_o(pwr),
      .left_pga_target_i(tgt), .sample_tick_i(tick),
      .left_pga_gain_o(gain), .left_pga_stepping_o(stp),
      .reserved_code_write_o(rsv));

   // ==========
   // tasks
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a inside {[8'h11:8'h13]})
         sh[a - 8'h11] = d;
   endtask

   task automatic rd_reg(logic [7:0] a, logic [7:0] e, logic h);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp("rdata", e, rdata);
      cmp("hit", {7'h0, h}, {7'h0, hit});
   endtask

   // decoded outputs settle two edges after the write edge
   task automatic chk_dec();
      logic [3:0] c [5];
      repeat (2) @(posedge clk);
      #1;
      c = '{sh[0][7:4], sh[0][3:0], sh[1][7:4], sh[1][3:0], sh[2][6:3]};
      for (int i = 0; i < 5; i++) begin
         cmp("connect", {7'h0, c[i] <= 4'h8}, {7'h0, conn[i]});
         cmp("atten", (c[i] <= 4'h8) ? 8'(c[i] * 3) : 8'h00,
             {3'h0, atten[i]});
      end
      cmp("diff", {7'h0, sh[2][7]}, {7'h0, diff});
      cmp("power", {7'h0, sh[2][2]}, {7'h0, pwr});
   endtask

   task automatic pulse(int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      #1;
   endtask

   task automatic results();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      results();
   end

   initial begin
      logic [3:0] c;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(rows[i].addr, rows[i].data);
         rd_reg(rows[i].addr, rows[i].exp, rows[i].hit);
         chk_dec();
      end
      // the reserved flag stands for one cycle only, right after the write
      wr_reg(8'h12, 8'hae);
      #1;
      cmp("reserved", 8'h01, {7'h0, rsv});
      @(posedge clk);
      #1;
      cmp("reserved", 8'h00, {7'h0, rsv});
      for (int i = 0; i < 10; i++) begin
         c = (i == 9) ? 4'hf : 4'(i);
         wr_reg(8'h11, {c, c});
         wr_reg(8'h12, {c, c});
         wr_reg(8'h13, {i[0], c, 1'b1, 2'(i)});
         chk_dec();
      end
      wr_reg(8'h13, 8'h04);
      tgt <= 7'h03;
      for (int i = 1; i <= 3; i++) begin
         pulse(1);
         cmp("gain", 8'(i), {1'b0, gain});
      end
      cmp("stepping", 8'h00, {7'h0, stp});
      wr_reg(8'h13, 8'h05);
      tgt <= 7'h00;
      pulse(4);
      cmp("gain", 8'h01, {1'b0, gain});
      cmp("stepping", 8'h01, {7'h0, stp});
      for (int r = 2; r < 4; r++) begin
         wr_reg(8'h13, {6'h01, 2'(r)});
         tgt <= 7'(r * 20);
         repeat (2) @(posedge clk);
         #1;
         cmp("gain", 8'(r * 20), {1'b0, gain});
      end
      // second reset in mid-run brings every register back
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      sh = '{8'hff, 8'hff, 8'h78};
      rd_reg(8'h11, 8'hff, 1'b1);
      rd_reg(8'h12, 8'hff, 1'b1);
      rd_reg(8'h13, 8'h78, 1'b1);
      chk_dec();
      cmp("gain", 8'h00, {1'b0, gain});
      cmp("stepping", 8'h01, {7'h0, stp});
      results();
   end
endmodule
